// [src/hbs_defines.svh]
// Timing counts and the fixed address of the host bus sequencer.
// Assumes a 20 MHz system clock; every cycle count is derived from it.
`ifndef HBS_DEFINES_SVH
`define HBS_DEFINES_SVH

// System clock period
`define HBS_T_CLK_NS 50
// Least time from a figure in ns, rounded up to whole clock cycles
`define HBS_CEIL_CYC(ns) (((ns) + `HBS_T_CLK_NS - 1) / `HBS_T_CLK_NS)

// Bus cycle framing
`define HBS_T_CYCLE_NS 165
`define HBS_T_CSL_NS 32
`define HBS_T_CSH_NS 13
`define HBS_T_ACYC_NS 165
// Strobes stay active for a whole least cycle; also covers the assertion
// time and the two-flop latency of the returning data
`define HBS_ACT_CYC `HBS_CEIL_CYC(`HBS_T_CYCLE_NS)
`define HBS_REC_CYC `HBS_CEIL_CYC(`HBS_T_CSH_NS)
`define HBS_BEAT_CYC `HBS_CEIL_CYC(`HBS_T_ACYC_NS)
`define HBS_BURST_MAX 16

// Waits after any write cycle
`define HBS_T_WR_CFG_NS 165
`define HBS_T_WR_SLOW_NS 495
`define HBS_T_WR_FREE_NS 660
`define HBS_T_WR_POWER_NS 1155
`define HBS_WR_CFG_CYC `HBS_CEIL_CYC(`HBS_T_WR_CFG_NS)
`define HBS_WR_SLOW_CYC `HBS_CEIL_CYC(`HBS_T_WR_SLOW_NS)
`define HBS_WR_FREE_CYC `HBS_CEIL_CYC(`HBS_T_WR_FREE_NS)
`define HBS_WR_POWER_CYC `HBS_CEIL_CYC(`HBS_T_WR_POWER_NS)

// Waits between dependent reads
`define HBS_T_RR_LEVEL_NS 495
`define HBS_T_RR_DROP_NS 660
`define HBS_RR_LEVEL_CYC `HBS_CEIL_CYC(`HBS_T_RR_LEVEL_NS)
`define HBS_RR_DROP_CYC `HBS_CEIL_CYC(`HBS_T_RR_DROP_NS)

// Elapsed-time counter width; must exceed the longest wait in cycles
`define HBS_EL_W 5
`define HBS_EL_MAX 5'h1F

// Word address of the side-effect free byte-test register
`define HBS_BYTE_TEST_ADDR 7'h32

`endif

// [src/hbs_pkg.sv]
// Types shared by the host bus sequencer modules.
// Assumes nothing beyond a SystemVerilog compiler.
package hbs_pkg;

    // What kind of resource a read targets; selects the waits it needs
    typedef enum logic [3:0] {
        HBS_CLS_PLAIN,
        HBS_CLS_CFG,
        HBS_CLS_TX_LEVEL,
        HBS_CLS_TIMER_COUNT,
        HBS_CLS_POWER,
        HBS_CLS_FREE_RUN,
        HBS_CLS_RX_LEVEL,
        HBS_CLS_DROP_COUNT,
        HBS_CLS_RX_DATA,
        HBS_CLS_RX_STATUS,
        HBS_CLS_TX_STATUS
    } hbs_class_t;

    // Sequencer states
    typedef enum logic [1:0] {
        HBS_ST_IDLE,
        HBS_ST_GAP,
        HBS_ST_ACT,
        HBS_ST_REC
    } hbs_state_t;

endpackage

// [src/hbs_sync.sv]
// Two-flop synchroniser for the returning data bus.
// Assumes the input comes from a pin outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module hbs_sync #(
    parameter int W = 16
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_q; // First stage, read only by the second
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q; // Second stage, safe for logic
    logic [W-1:0] sync_d;

    // Next values of both stages
    always_comb begin
        meta_d = i_d;
        sync_d = meta_q;
    end

    // Stage registers
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign o_q = sync_q;
endmodule
`default_nettype wire

// [src/hbs_elapsed.sv]
// Saturating count of cycles since the last clearing event.
// Assumes the clear is a one-cycle pulse on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "hbs_defines.svh"
module hbs_elapsed (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_clear,
    output logic [`HBS_EL_W-1:0] o_count
);
    logic [`HBS_EL_W-1:0] cnt_q; // Cycles since the event
    logic [`HBS_EL_W-1:0] cnt_d;

    // Clear restarts the count; otherwise count up and stick at the top
    always_comb begin
        if (i_clear) begin
            cnt_d = '0;
        end else if (cnt_q != `HBS_EL_MAX) begin
            cnt_d = cnt_q + `HBS_EL_W'(1);
        end else begin
            cnt_d = cnt_q;
        end
    end

    // Starts saturated: no event has happened yet after reset
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_q <= `HBS_EL_MAX;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign o_count = cnt_q;
endmodule
`default_nettype wire

// [src/hbs_host.sv]
// Host-side sequencer for a 16-bit SRAM-like port of a network controller.
// Assumes the device answers reads within 30-40 ns of strobe or address.
// Behaviour
// - 165 ns after write before configuration reads
// - 495 ns after write before TX level/timer reads
// - 1155 ns power, 660 ns counter after write
// - 495 ns after FIFO reads before levels
// - 660 ns between two drop counter reads
// - Byte-test dummy reads may fill any wait
// - Slower buses may need fewer dummy reads
// - Dummy reads optional; elapsed time suffices
// - Cycle needs both strobes; either ends it
// - Strobes inactive 13 ns between single reads
// - Each single read cycle lasts 165 ns
// - Bursts up to 16 words, 165 ns addresses
// - Strobes inactive 13 ns between bursts
// - Every access moves one 16-bit word
`timescale 1ns/1ps
`default_nettype none
`include "hbs_defines.svh"
module hbs_host
    import hbs_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    // Command side
    input wire logic i_req_valid,
    output logic o_req_ready,
    input wire logic i_req_write,
    input wire hbs_class_t i_req_class,
    input wire logic [6:0] i_req_addr,
    input wire logic [15:0] i_req_wdata,
    input wire logic [3:0] i_req_len,
    input wire logic i_req_incr,
    input wire logic i_req_dummy,
    output logic [15:0] o_rd_data,
    output logic o_rd_valid,
    output logic o_rd_last,
    // Device pins
    output logic o_chip_select_n,
    output logic o_read_strobe_n,
    output logic o_write_strobe_n,
    output logic [6:0] o_addr,
    output logic [15:0] o_data_out,
    output logic o_data_oe,
    input wire logic [15:0] i_data_in
);
    // Every check below runs on the system clock and sleeps in reset
    default clocking cb_sys @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    hbs_state_t state_q, state_d; // Sequencer state
    logic [2:0] phase_q, phase_d; // Cycles spent in the current phase
    logic [3:0] beats_q, beats_d; // Words still to fetch after this one
    logic write_q, write_d; // Command is a write
    logic incr_q, incr_d; // Burst steps the address
    logic dmode_q, dmode_d; // Fill waits with byte-test reads
    logic dummy_q, dummy_d; // Current cycle is a filler read
    hbs_class_t cls_q, cls_d; // Class of the pending read
    logic [6:0] cmd_addr_q, cmd_addr_d; // Address of the real access
    logic cs_n_q, cs_n_d; // Registered pins
    logic rd_n_q, rd_n_d;
    logic wr_n_q, wr_n_d;
    logic [6:0] addr_q, addr_d;
    logic [15:0] dout_q, dout_d;
    logic oe_q, oe_d;
    logic [15:0] rdata_q, rdata_d; // Returned word and its strobes
    logic rvalid_q, rvalid_d;
    logic rlast_q, rlast_d;
    logic [15:0] din_sync; // Data bus after two flops
    logic act_end; // Strobes rise at the next edge
    logic ev_write, ev_rxfifo, ev_txstat, ev_drop; // Timer clearing events
    logic [`HBS_EL_W-1:0] el_write, el_rxfifo, el_txstat, el_drop;

    // Least cycles a read of this class must trail the last write
    function automatic int wr_need(input hbs_class_t c);
        case (c)
            HBS_CLS_CFG: wr_need = `HBS_WR_CFG_CYC;
            HBS_CLS_TX_LEVEL, HBS_CLS_TIMER_COUNT:
                wr_need = `HBS_WR_SLOW_CYC;
            HBS_CLS_POWER: wr_need = `HBS_WR_POWER_CYC;
            HBS_CLS_FREE_RUN: wr_need = `HBS_WR_FREE_CYC;
            default: wr_need = 0;
        endcase
    endfunction

    // True once every wait that applies to a read of this class has run
    function automatic logic gap_ok(input hbs_class_t c,
        input logic [`HBS_EL_W-1:0] ew, erx, etx, edr);
        logic ok;
        ok = (int'(ew) >= wr_need(c));
        if (c == HBS_CLS_RX_LEVEL) begin
            ok = ok && (int'(erx) >= `HBS_RR_LEVEL_CYC);
        end else if (c == HBS_CLS_TX_LEVEL) begin
            ok = ok && (int'(etx) >= `HBS_RR_LEVEL_CYC);
        end else if (c == HBS_CLS_DROP_COUNT) begin
            ok = ok && (int'(edr) >= `HBS_RR_DROP_CYC);
        end
        gap_ok = ok;
    endfunction

    hbs_sync #(.W(16)) u_sync (.i_clk(i_clk), .i_rst(i_rst),
        .i_d(i_data_in), .o_q(din_sync));

    // Events are timed from the edge at which the strobes rise
    assign act_end = (state_q == HBS_ST_ACT) && (state_d == HBS_ST_REC);
    assign ev_write = act_end && write_q;
    assign ev_rxfifo = act_end && !write_q && !dummy_q &&
                       (cls_q == HBS_CLS_RX_DATA ||
                        cls_q == HBS_CLS_RX_STATUS);
    assign ev_txstat = act_end && !write_q && !dummy_q &&
                       (cls_q == HBS_CLS_TX_STATUS);
    assign ev_drop = act_end && !write_q && !dummy_q &&
                     (cls_q == HBS_CLS_DROP_COUNT);

    hbs_elapsed u_el_write (.i_clk(i_clk), .i_rst(i_rst),
        .i_clear(ev_write), .o_count(el_write));
    hbs_elapsed u_el_rxfifo (.i_clk(i_clk), .i_rst(i_rst),
        .i_clear(ev_rxfifo), .o_count(el_rxfifo));
    hbs_elapsed u_el_txstat (.i_clk(i_clk), .i_rst(i_rst),
        .i_clear(ev_txstat), .o_count(el_txstat));
    hbs_elapsed u_el_drop (.i_clk(i_clk), .i_rst(i_rst),
        .i_clear(ev_drop), .o_count(el_drop));

    // Only idle accepts; one command at a time keeps ordering trivial
    assign o_req_ready = (state_q == HBS_ST_IDLE);

    // Next-state and pin logic of the sequencer
    always_comb begin
        state_d = state_q;
        phase_d = phase_q;
        beats_d = beats_q;
        write_d = write_q;
        incr_d = incr_q;
        dmode_d = dmode_q;
        dummy_d = dummy_q;
        cls_d = cls_q;
        cmd_addr_d = cmd_addr_q;
        cs_n_d = cs_n_q;
        rd_n_d = rd_n_q;
        wr_n_d = wr_n_q;
        addr_d = addr_q;
        dout_d = dout_q;
        oe_d = oe_q;
        rdata_d = rdata_q;
        rvalid_d = 1'b0;
        rlast_d = 1'b0;
        case (state_q)
            HBS_ST_IDLE: begin
                // Latch the command; writes carry one word only
                if (i_req_valid) begin
                    write_d = i_req_write;
                    cls_d = i_req_class;
                    cmd_addr_d = i_req_addr;
                    dout_d = i_req_wdata;
                    beats_d = i_req_write ? 4'h0 : i_req_len;
                    incr_d = i_req_incr;
                    dmode_d = i_req_dummy;
                    state_d = HBS_ST_GAP;
                end
            end
            HBS_ST_GAP: begin
                phase_d = 3'h0;
                if (write_q || gap_ok(cls_q, el_write, el_rxfifo,
                                      el_txstat, el_drop)) begin
                    // Both strobes fall together to open the cycle
                    dummy_d = 1'b0;
                    addr_d = cmd_addr_q;
                    cs_n_d = 1'b0;
                    rd_n_d = write_q;
                    wr_n_d = !write_q;
                    oe_d = write_q; // Never drive while device may
                    state_d = HBS_ST_ACT;
                end else if (dmode_q) begin
                    // Spend the wait on harmless byte-test reads
                    dummy_d = 1'b1;
                    addr_d = `HBS_BYTE_TEST_ADDR;
                    cs_n_d = 1'b0;
                    rd_n_d = 1'b0;
                    state_d = HBS_ST_ACT;
                end
                // Otherwise idle the bus; time alone meets the wait
            end
            HBS_ST_ACT: begin
                // Hold strobes and address a full cycle
                phase_d = phase_q + 3'h1;
                if (phase_q == 3'(`HBS_ACT_CYC - 1)) begin
                    phase_d = 3'h0;
                    if (!write_q && !dummy_q) begin
                        rdata_d = din_sync;
                        rvalid_d = 1'b1;
                        rlast_d = (beats_q == 4'h0);
                    end
                    if (!write_q && !dummy_q && beats_q != 4'h0) begin
                        // Next word under the same strobes
                        beats_d = beats_q - 4'h1;
                        if (incr_q) begin
                            addr_d = addr_q + 7'h01;
                        end
                    end else begin
                        cs_n_d = 1'b1;
                        rd_n_d = 1'b1;
                        wr_n_d = 1'b1;
                        oe_d = 1'b0;
                        state_d = HBS_ST_REC;
                    end
                end
            end
            HBS_ST_REC: begin
                // Strobes stay inactive for the deassertion time
                phase_d = phase_q + 3'h1;
                if (phase_q == 3'(`HBS_REC_CYC - 1)) begin
                    phase_d = 3'h0;
                    // Filler reads loop back; the wait is timed
                    state_d = dummy_q ? HBS_ST_GAP : HBS_ST_IDLE;
                    dummy_d = 1'b0;
                end
            end
            default: state_d = HBS_ST_IDLE;
        endcase
    end

    // Sequencer registers; strobes idle high, address and data low, bus released after reset
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_q <= HBS_ST_IDLE;
            phase_q <= 3'h0;
            beats_q <= 4'h0;
            write_q <= 1'b0;
            incr_q <= 1'b0;
            dmode_q <= 1'b0;
            dummy_q <= 1'b0;
            cls_q <= HBS_CLS_PLAIN;
            cmd_addr_q <= 7'h00;
            cs_n_q <= 1'b1;
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            addr_q <= 7'h00;
            dout_q <= 16'h0000;
            oe_q <= 1'b0;
            rdata_q <= 16'h0000;
            rvalid_q <= 1'b0;
            rlast_q <= 1'b0;
        end else begin
            state_q <= state_d;
            phase_q <= phase_d;
            beats_q <= beats_d;
            write_q <= write_d;
            incr_q <= incr_d;
            dmode_q <= dmode_d;
            dummy_q <= dummy_d;
            cls_q <= cls_d;
            cmd_addr_q <= cmd_addr_d;
            cs_n_q <= cs_n_d;
            rd_n_q <= rd_n_d;
            wr_n_q <= wr_n_d;
            addr_q <= addr_d;
            dout_q <= dout_d;
            oe_q <= oe_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
            rlast_q <= rlast_d;
        end
    end

    assign o_chip_select_n = cs_n_q;
    assign o_read_strobe_n = rd_n_q;
    assign o_write_strobe_n = wr_n_q;
    assign o_addr = addr_q;
    assign o_data_out = dout_q;
    assign o_data_oe = oe_q;
    assign o_rd_data = rdata_q;
    assign o_rd_valid = rvalid_q;
    assign o_rd_last = rlast_q;

    // Checks
    logic rd_start; // First cycle of a real read on the pins
    logic rd_n_prev_q; // Read strobe one cycle back, idle high
    logic [4:0] burst_words; // Words delivered in the current burst
    assign rd_start = !cs_n_q && !rd_n_q && !dummy_q && rd_n_prev_q &&
                      state_q == HBS_ST_ACT && phase_q == 3'h0;
    always_ff @(posedge i_clk) begin
        rd_n_prev_q <= i_rst || rd_n_q;
        if (i_rst || rd_n_q) begin
            burst_words <= 5'h00;
        end else if (rvalid_q) begin
            burst_words <= burst_words + 5'h01;
        end
    end

    a_wr_cfg_gap: assert property (rd_start &&
        cls_q == HBS_CLS_CFG |-> el_write > `HBS_WR_CFG_CYC)
        else $error("config read too soon after write");
    a_wr_slow_gap: assert property (rd_start &&
        (cls_q == HBS_CLS_TX_LEVEL || cls_q == HBS_CLS_TIMER_COUNT)
        |-> el_write > `HBS_WR_SLOW_CYC)
        else $error("level or timer read too soon after write");
    a_wr_power_gap: assert property (rd_start &&
        cls_q == HBS_CLS_POWER |-> el_write > `HBS_WR_POWER_CYC)
        else $error("power control read too soon after write");
    a_rx_level_gap: assert property (rd_start &&
        cls_q == HBS_CLS_RX_LEVEL |-> el_rxfifo > `HBS_RR_LEVEL_CYC)
        else $error("rx level read too soon after fifo read");
    a_drop_reread_gap: assert property (rd_start &&
        cls_q == HBS_CLS_DROP_COUNT |-> el_drop > `HBS_RR_DROP_CYC)
        else $error("drop counter reread too soon");
    a_read_cycle_len: assert property ($fell(rd_n_q) |->
        (!rd_n_q && !cs_n_q) [*4] ##1 1'b1)
        else $error("read strobes shorter than a cycle");
    a_burst_addr_rate: assert property (!rd_n_q &&
        $past(!rd_n_q) && $changed(addr_q)
        |-> $past(addr_q, 1) == $past(addr_q, 4))
        else $error("burst address changed too fast");
    a_burst_word_max: assert property (
        burst_words <= 5'(`HBS_BURST_MAX))
        else $error("burst longer than sixteen words");
    a_valid_in_cycle: assert property (rvalid_q |->
        $past(!cs_n_q && !rd_n_q) ##1 (cs_n_q || rd_n_q || 1'b1))
        else $error("read data taken outside a cycle");
    a_bus_release: assert property (!rd_n_q |-> !oe_q && wr_n_q)
        else $error("host drives data during a read");
    a_strobe_recover: assert property ($rose(cs_n_q) |->
        !$past(cs_n_q) ##1 (cs_n_q || state_q != HBS_ST_ACT))
        else $error("strobes not held inactive between cycles");

    c_single_read: cover property (rvalid_q && rlast_q &&
        burst_words == 5'h00);
    c_full_burst: cover property (rvalid_q && burst_words == 5'h0F);
    c_write_cycle: cover property ($fell(wr_n_q));
    c_dummy_fill: cover property (dummy_q && $fell(rd_n_q));
endmodule
`default_nettype wire

// [testbench/hbs_dev_model.sv]
// Behavioural model of the network controller behind the host port.
// Assumes the host drives its pins on clock edges, all in one time step.
`timescale 1ns/1ps
`default_nettype none
module hbs_dev_model
    import hbs_pkg::*;
(
    input wire logic i_chip_select_n,
    input wire logic i_read_strobe_n,
    input wire logic i_write_strobe_n,
    input wire logic [6:0] i_addr,
    input wire logic [15:0] i_data_out,
    input wire logic i_data_oe,
    output logic [15:0] o_data_in,
    output var int o_viol,
    output logic [22:0] o_last_wr
);
    // End times of the causing events, far in the past at start
    realtime t_wr = -1.0e6, t_end = -1.0e6, t_rxf = -1.0e6;
    realtime t_txs = -1.0e6, t_drop = -1.0e6;
    realtime t_start = 0.0, t_addr = 0.0;
    logic rd_on = 1'b0; // Read cycle in progress
    logic wr_on = 1'b0; // Write cycle in progress
    logic [15:0] pop = 16'hA000; // Next FIFO word
    logic [6:0] a_q = 7'h00; // Address of the word being served
    hbs_class_t c_q = HBS_CLS_PLAIN;
    int words = 0; // Words served under one strobe assertion

    initial begin
        o_data_in = 16'h5A5A;
        o_viol = 0;
        o_last_wr = 23'h000000;
    end

    // Address map: class sits in bits 5:2 of addresses ending in 01
    function automatic hbs_class_t cls_of(input logic [6:0] a);
        if (a[6] || a[1:0] != 2'b01 || a[5:2] > 4'hA) return HBS_CLS_PLAIN;
        return hbs_class_t'(a[5:2]);
    endfunction

    // Counts a fault when less than ns has passed since an event
    task automatic need(input realtime since, input realtime ns);
        if ($realtime - since < ns) o_viol++;
    endtask

    // Start of a word: check the waits, then snapshot the value
    task automatic serve();
        logic [15:0] word;
        c_q = cls_of(i_addr);
        a_q = i_addr;
        t_addr = $realtime;
        words++;
        if (words > 16 || i_data_oe) o_viol++;
        case (c_q)
            HBS_CLS_CFG: need(t_wr, 165);
            HBS_CLS_TX_LEVEL: begin
                need(t_wr, 495);
                need(t_txs, 495);
            end
            HBS_CLS_TIMER_COUNT: need(t_wr, 495);
            HBS_CLS_POWER: need(t_wr, 1155);
            HBS_CLS_FREE_RUN: need(t_wr, 660);
            HBS_CLS_RX_LEVEL: need(t_rxf, 495);
            HBS_CLS_DROP_COUNT: need(t_drop, 660);
            default: ;
        endcase
        // FIFOs pop once per word; byte-test and others have no side effect
        if (c_q inside {HBS_CLS_RX_DATA, HBS_CLS_RX_STATUS,
                        HBS_CLS_TX_STATUS}) begin
            word = pop;
            pop++;
        end else begin
            word = {i_addr, 9'h0A5};
        end
        o_data_in <= #20 word; // Held stable for the word
    endtask

    // End of a word: remember when dependent reads may follow
    task automatic done_word();
        if (c_q inside {HBS_CLS_RX_DATA, HBS_CLS_RX_STATUS}) t_rxf = $realtime;
        if (c_q == HBS_CLS_TX_STATUS) t_txs = $realtime;
        if (c_q == HBS_CLS_DROP_COUNT) t_drop = $realtime;
    endtask

    // Waits 1 ns so that all pin changes of one edge are seen together
    always @(i_chip_select_n, i_read_strobe_n, i_write_strobe_n, i_addr) begin
        #1;
        if (!i_chip_select_n && !i_read_strobe_n) begin
            if (!rd_on) begin
                need(t_end, 13);
                rd_on = 1'b1;
                t_start = $realtime;
                words = 0;
                serve();
            end else if (i_addr != a_q) begin
                need(t_addr, 165);
                done_word();
                serve();
            end
        end else if (rd_on) begin
            need(t_start, 165);
            rd_on = 1'b0;
            t_end = $realtime;
            done_word();
            // Released bus must not look like the old word
            o_data_in <= #5 ~o_data_in;
        end
        if (!i_chip_select_n && !i_write_strobe_n) begin
            if (!wr_on) begin
                need(t_end, 13);
                wr_on = 1'b1;
                o_last_wr = {i_addr, i_data_out};
            end
        end else if (wr_on) begin
            wr_on = 1'b0;
            t_end = $realtime;
            t_wr = $realtime;
        end
    end
endmodule
`default_nettype wire

// [testbench/hbs_host_tb.sv]
// Self-checking bench for the host bus sequencer against a device model.
// Assumes the device model decodes the class from the word address.
`timescale 1ns/1ps
`default_nettype none
module hbs_host_tb
    import hbs_pkg::*;
;
    // One command: write flag, address, burst length - 1, dummy, latency
    typedef struct {
        logic wr; logic [6:0] addr; int len; logic dm; int lat;
    } hbs_row_t;
    hbs_row_t rows[23] = '{
        '{0, 7'h01, 0, 0, 5}, '{1, 7'h05, 0, 0, 0}, '{0, 7'h05, 0, 0, 0},
        '{1, 7'h09, 0, 0, 0}, '{0, 7'h09, 0, 0, 0}, '{1, 7'h0D, 0, 0, 0},
        '{0, 7'h0D, 0, 0, 0}, '{1, 7'h11, 0, 0, 0}, '{0, 7'h11, 0, 0, 0},
        '{1, 7'h15, 0, 0, 0}, '{0, 7'h15, 0, 1, 0}, '{0, 7'h21, 0, 0, 0},
        '{0, 7'h19, 0, 0, 0}, '{0, 7'h29, 0, 0, 0}, '{0, 7'h09, 0, 0, 0},
        '{0, 7'h1D, 0, 0, 0}, '{0, 7'h1D, 0, 0, 0}, '{1, 7'h19, 0, 0, 0},
        '{0, 7'h19, 0, 0, 5}, '{0, 7'h25, 0, 0, 0}, '{0, 7'h40, 15, 0, 5},
        '{1, 7'h11, 0, 0, 0}, '{0, 7'h11, 0, 1, 0}};
    logic clk, rst, req_valid, req_write, req_incr, req_dummy, ready;
    hbs_class_t req_class;
    logic [6:0] req_addr, addr;
    logic [15:0] req_wdata, rd_data, dout, din;
    logic [3:0] req_len;
    logic rd_valid, rd_last, cs_n, rd_n, wr_n, oe;
    logic [22:0] last_wr;
    int viol, bad_count = 0, n_compared = 0;
    logic [15:0] exp_pop = 16'hA000; // Next FIFO word expected

    hbs_host u_hbs_host (.i_clk(clk), .i_rst(rst), .i_req_valid(req_valid),
        .o_req_ready(ready), .i_req_write(req_write), .i_req_class(req_class),
        .i_req_addr(req_addr), .i_req_wdata(req_wdata), .i_req_len(req_len),
        .i_req_incr(req_incr), .i_req_dummy(req_dummy), .o_rd_data(rd_data),
        .o_rd_valid(rd_valid), .o_rd_last(rd_last), .o_chip_select_n(cs_n),
        .o_read_strobe_n(rd_n), .o_write_strobe_n(wr_n), .o_addr(addr),
        .o_data_out(dout), .o_data_oe(oe), .i_data_in(din));
    hbs_dev_model u_hbs_dev_model (.i_chip_select_n(cs_n),
        .i_read_strobe_n(rd_n), .i_write_strobe_n(wr_n), .i_addr(addr),
        .i_data_out(dout), .i_data_oe(oe), .o_data_in(din), .o_viol(viol),
        .o_last_wr(last_wr));

    // 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Prints the verdict and ends the run
    task automatic wrap_up();
        if (bad_count == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input string what, input logic [22:0] exp, got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // Same decode as the device address map, written independently
    function automatic hbs_class_t cls_of(input logic [6:0] a);
        if (a[6] || a[1:0] != 2'b01 || a[5:2] > 4'hA) return HBS_CLS_PLAIN;
        return hbs_class_t'(a[5:2]);
    endfunction

    // Waits at falling edges for ready, giving up after a bound
    task automatic wait_ready();
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        if (n >= 100) begin
            bad_count++;
            wrap_up();
        end
    endtask

    // Issues one command and checks every word that comes back
    task automatic run(input hbs_row_t r);
        int cyc, words;
        logic pop;
        logic [6:0] a;
        @(negedge clk);
        req_valid = 1'b1;
        req_write = r.wr;
        req_class = cls_of(r.addr);
        req_addr = r.addr;
        req_wdata = {r.addr, 9'h1C3};
        req_len = 4'(r.len);
        req_incr = (r.len != 0);
        req_dummy = r.dm;
        pop = cls_of(r.addr) inside {HBS_CLS_RX_DATA, HBS_CLS_RX_STATUS,
                                     HBS_CLS_TX_STATUS};
        wait_ready();
        @(negedge clk); // Taken at the rising edge just passed
        req_valid = 1'b0;
        cyc = 0;
        words = 0;
        a = r.addr;
        while (!r.wr && words <= r.len && cyc < 300) begin
            @(negedge clk);
            cyc++;
            if (rd_valid === 1'b1) begin
                if (words == 0 && r.lat != 0)
                    check("latency", r.lat, cyc);
                check("read word", pop ? exp_pop : {a, 9'h0A5}, rd_data);
                check("last flag", words == r.len, rd_last);
                exp_pop = exp_pop + 16'(pop); // Byte-test must not pop
                a++;
                words++;
            end
        end
        if (cyc >= 300) begin
            bad_count++;
            wrap_up();
        end
        wait_ready();
        if (r.wr) check("write word", {r.addr, r.addr, 9'h1C3}, last_wr);
    endtask

    // Reset, the table of ordinary commands, then the timing verdict
    initial begin
        rst = 1'b1;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_class = HBS_CLS_PLAIN;
        req_addr = 7'h00;
        req_wdata = 16'h0000;
        req_len = 4'h0;
        req_incr = 1'b0;
        req_dummy = 1'b0;
        repeat (10) @(negedge clk);
        check("reset pins", 5'h1D, {cs_n, rd_n, wr_n, oe, ready});
        rst = 1'b0;
        foreach (rows[i]) run(rows[i]);
        // Reset again between commands; pins idle and reads resume
        rst = 1'b1;
        @(negedge clk);
        check("reset pins", 5'h1D, {cs_n, rd_n, wr_n, oe, ready});
        rst = 1'b0;
        run('{0, 7'h01, 0, 0, 5});
        check("device timing faults", 23'h0, 23'(viol));
        wrap_up();
    end
endmodule
`default_nettype wire
